// File: spi3_params.svh
`ifndef SPI3_PARAMS_SVH
`define SPI3_PARAMS_SVH

`define SPI3_ADDR_W 7
`define SPI3_DATA_W 8
`define SPI3_BITS_PER_BYTE 4'h8
`define SPI3_LAST_BIT 3'h7
`define SPI3_DIR_READ 1'h1
`define SPI3_REG_RESET 8'h00
`define SPI3_BUF_DEPTH 2

`endif

// File: spi3_pkg.sv
package spi3_pkg;
  `include "spi3_params.svh"

  // one register access as seen by the register space
  typedef struct packed {
    logic [`SPI3_ADDR_W-1:0] addr;
    logic [`SPI3_DATA_W-1:0] data;
  } reg_word_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b100
  } xfer_state_type;
endpackage

// File: spi3_skid_buffer.sv
`timescale 1ns/1ps
// two-entry buffer; a stalled receiver loses no committed write while an entry is free
module spi3_skid_buffer
  import spi3_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire reg_word_type i_word,
  output logic o_valid,
  input wire logic i_ready,
  output reg_word_type o_word
);
  typedef struct packed {
    reg_word_type [1:0] mem;
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] count;
  } buf_state_type;

  buf_state_type state_ff;
  buf_state_type nxt_state;
  logic push;
  logic pop;

  assign push = i_valid && (state_ff.count != 2'h2);
  assign pop = o_valid && i_ready;
  assign o_ready = (state_ff.count != 2'h2);
  assign o_valid = (state_ff.count != 2'h0);
  assign o_word = state_ff.mem[state_ff.rd_ptr];

  // pointer and occupancy update
  always_comb begin
    nxt_state = state_ff;
    if (push) begin
      nxt_state.mem[state_ff.wr_ptr] = i_word;
      nxt_state.wr_ptr = ~state_ff.wr_ptr;
    end
    if (pop) begin
      nxt_state.rd_ptr = ~state_ff.rd_ptr;
    end
    nxt_state.count = 2'(state_ff.count + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end
endmodule

// File: spi3_reg_slave.sv
`timescale 1ns/1ps
`include "spi3_params.svh"
module spi3_reg_slave
  import spi3_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_serial_clk,
  input wire logic i_select_low_n,
  input wire logic i_serial_data_i,
  output logic o_serial_data_o,
  output logic o_serial_data_oe_n,
  input wire logic i_read_edge_select,
  input wire logic i_reg_ready,
  output logic o_reg_valid,
  output logic [`SPI3_ADDR_W-1:0] o_reg_addr,
  output logic [`SPI3_DATA_W-1:0] o_reg_data,
  output logic o_busy
);
  typedef struct packed {
    logic [1:0] sclk_sync;
    logic [1:0] sel_sync;
    logic [1:0] din_sync;
    logic sclk_prev;
    xfer_state_type st;
    logic [2:0] bit_cnt;
    logic [`SPI3_DATA_W-1:0] shreg;
    logic [`SPI3_ADDR_W-1:0] addr;
    logic [`SPI3_DATA_W-1:0] rd_shift;
    logic dout;
    logic oe_n;
    logic busy;
  } slave_state_type;

  slave_state_type state_ff;
  slave_state_type nxt_state;
  logic [`SPI3_DATA_W-1:0] regs [0:(1<<`SPI3_ADDR_W)-1];
  reg_word_type wr_word;
  reg_word_type buf_word;
  logic wr_valid;
  logic wr_ready;
  logic buf_valid;
  logic sclk_s;
  logic sel_n_s;
  logic din_s;
  logic rise;
  logic fall;
  logic launch;
  logic [2:0] rd_idx;
  logic [`SPI3_DATA_W-1:0] byte_in;

  // only the second stage of each synchroniser is read
  assign sclk_s = state_ff.sclk_sync[1];
  assign sel_n_s = state_ff.sel_sync[1];
  assign din_s = state_ff.din_sync[1];
  assign rise = sclk_s && !state_ff.sclk_prev;
  assign fall = !sclk_s && state_ff.sclk_prev;
  assign launch = i_read_edge_select ? rise : fall;
  // a rising launch sees the count before its own increment,
  // so it must present the bit one ahead
  assign rd_idx = i_read_edge_select ? 3'(state_ff.bit_cnt + 3'h1)
                                     : state_ff.bit_cnt;
  // lsb arrives first, so new bits enter at the top
  assign byte_in = {din_s, state_ff.shreg[`SPI3_DATA_W-1:1]};

  // transfer engine; serial clock is oversampled by the reference clock
  always_comb begin
    nxt_state = state_ff;
    wr_valid = 1'b0;
    wr_word = '0;
    nxt_state.sclk_sync = {state_ff.sclk_sync[0], i_serial_clk};
    nxt_state.sel_sync = {state_ff.sel_sync[0], i_select_low_n};
    nxt_state.din_sync = {state_ff.din_sync[0], i_serial_data_i};
    nxt_state.sclk_prev = sclk_s;
    if (sel_n_s) begin
      nxt_state.st = ST_IDLE;
      nxt_state.bit_cnt = 3'h0;
      nxt_state.oe_n = 1'b1;
      nxt_state.busy = 1'b0;
    end else begin
      nxt_state.busy = 1'b1;
      if (rise) begin
        nxt_state.shreg = byte_in;
        nxt_state.bit_cnt = 3'(state_ff.bit_cnt + 3'h1);
      end
      unique case (state_ff.st)
        ST_IDLE: begin
          if (rise && state_ff.bit_cnt == `SPI3_LAST_BIT) begin
            // bit 0 on the wire is direction, then address lsb first
            nxt_state.addr = byte_in[`SPI3_DATA_W-1:1];
            if (byte_in[0] == `SPI3_DIR_READ) begin
              nxt_state.st = ST_READ;
              nxt_state.rd_shift = regs[byte_in[`SPI3_DATA_W-1:1]];
              nxt_state.dout = regs[byte_in[`SPI3_DATA_W-1:1]][0];
              nxt_state.oe_n = 1'b0;
            end else begin
              nxt_state.st = ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          // commit only on the last bit of a full byte
          if (rise && state_ff.bit_cnt == `SPI3_LAST_BIT) begin
            wr_valid = 1'b1;
            wr_word.addr = state_ff.addr;
            wr_word.data = byte_in;
            nxt_state.addr = 7'(state_ff.addr + 7'h1);
          end
        end
        ST_READ: begin
          if (launch) begin
            if (rd_idx == 3'h0) begin
              // byte boundary: fetch the register the address points at
              nxt_state.rd_shift = regs[state_ff.addr];
              nxt_state.dout = regs[state_ff.addr][0];
            end else begin
              nxt_state.dout = state_ff.rd_shift[rd_idx];
            end
            // step the address on the last bit so the next fetch is A+1
            if (rd_idx == `SPI3_LAST_BIT) begin
              nxt_state.addr = 7'(state_ff.addr + 7'h1);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= '{sclk_sync: 2'h0, sel_sync: 2'h3, din_sync: 2'h0,
                    sclk_prev: 1'b0, st: ST_IDLE, bit_cnt: 3'h0,
                    shreg: 8'h00, addr: 7'h00, rd_shift: 8'h00,
                    dout: 1'b0, oe_n: 1'b1, busy: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // register space; writes land from the buffer, so a stall loses nothing until both buffer entries are full
  always_ff @(posedge i_ref_clk) begin
    if (buf_valid) begin
      regs[buf_word.addr] <= buf_word.data;
    end
  end

  // outputs are registered copies of the drained word
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_valid <= 1'b0;
      o_reg_addr <= 7'h00;
      o_reg_data <= `SPI3_REG_RESET;
    end else begin
      o_reg_valid <= buf_valid && i_reg_ready;
      if (buf_valid && i_reg_ready) begin
        o_reg_addr <= buf_word.addr;
        o_reg_data <= buf_word.data;
      end
    end
  end

  assign o_serial_data_o = state_ff.dout;
  assign o_serial_data_oe_n = state_ff.oe_n;
  assign o_busy = state_ff.busy;

  spi3_skid_buffer u_buf (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_valid(wr_valid),
    .o_ready(wr_ready),
    .i_word(wr_word),
    .o_valid(buf_valid),
    .i_ready(i_reg_ready),
    .o_word(buf_word)
  );
endmodule

// File: spi3_reg_checker.sv
`timescale 1ns/1ps
// watches the pin enable and select framing of the register slave
module spi3_reg_checker(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_serial_clk,
  input wire logic i_select_low_n,
  input wire logic o_serial_data_o,
  input wire logic o_serial_data_oe_n,
  input wire logic i_read_edge_select,
  input wire logic o_busy
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // six cycles covers the select synchroniser
  sequence sel_quiet;
    i_select_low_n [*6];
  endsequence
  // a data change well after the pin turned round
  sequence pin_change;
    !o_serial_data_oe_n [*3] ##1
      (!o_serial_data_oe_n && $changed(o_serial_data_o));
  endsequence
  pin_released_a: assert property (sel_quiet |-> o_serial_data_oe_n)
    else $error("pin driven while deselected");
  busy_clear_a: assert property (sel_quiet |-> !o_busy)
    else $error("busy kept after deselect");
  busy_set_a: assert property ($fell(i_select_low_n) |-> ##[1:5] o_busy)
    else $error("busy not raised by select");
  pin_input_a: assert property (
    $fell(i_select_low_n) |-> o_serial_data_oe_n [*6])
    else $error("pin driven at frame start");
  drive_busy_a: assert property ($fell(o_serial_data_oe_n) |-> o_busy)
    else $error("pin driven outside a frame");
  drive_hold_a: assert property (
    !o_serial_data_oe_n && !i_select_low_n |=> !o_serial_data_oe_n)
    else $error("pin released mid read");
  launch_fall_a: assert property (
    pin_change ##0 !i_read_edge_select |-> !i_serial_clk)
    else $error("read bit moved off the falling edge");
  launch_rise_a: assert property (
    pin_change ##0 i_read_edge_select |-> i_serial_clk)
    else $error("read bit moved off the rising edge");
endmodule

bind spi3_reg_slave spi3_reg_checker chk(.*);

// File: spi3_master_model.sv
`timescale 1ns/1ps
// serial master; its clock parks low outside frames
module spi3_master_model(
  input wire logic i_ref_clk,
  input wire logic i_line,
  output logic o_sclk = 1'b0,
  output logic o_cs_n = 1'b1,
  output logic o_sdi = 1'b0
);
  // half period of 8 ref cycles keeps the link under 20 MHz
  task automatic half();
    repeat (8) @(posedge i_ref_clk);
  endtask
  task automatic frame_on();
    o_cs_n <= 1'b0;
    half();
  endtask
  // select lifts after a falling edge, on a byte boundary only
  task automatic frame_off();
    o_sclk <= 1'b0;
    half();
    o_cs_n <= 1'b1;
    repeat (16) @(posedge i_ref_clk);
  endtask
  // whole byte, lsb first; when not driving, the line gets the inverse
  task automatic byte_io(input logic [7:0] tx, input logic drv,
      output logic [7:0] rx);
    for (int i = 0; i < 8; i++) begin
      o_sclk <= 1'b0;
      o_sdi <= drv ? tx[i] : ~o_sdi;
      half();
      rx[i] = i_line;
      o_sclk <= 1'b1;
      half();
    end
  endtask
endmodule

// File: test_spi3_reg_slave.sv
`timescale 1ns/1ps
module test_spi3_reg_slave;
  logic i_ref_clk = 1'b0, i_rst_n = 1'b0;
  logic i_reg_ready = 1'b1, i_read_edge_select = 1'b0;
  logic i_serial_clk, i_select_low_n, sdi_m, o_serial_data_o;
  logic o_serial_data_oe_n, o_reg_valid, o_busy;
  logic [6:0] o_reg_addr;
  logic [7:0] o_reg_data;
  logic [14:0] got[$];
  int fail_count = 0, comparisons = 0;
  // the device owns the line while its enable is low
  wire logic i_serial_data_i = o_serial_data_oe_n ? sdi_m : o_serial_data_o;
  initial begin
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  spi3_reg_slave dut(
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_serial_clk(i_serial_clk),
    .i_select_low_n(i_select_low_n),
    .i_serial_data_i(i_serial_data_i),
    .o_serial_data_o(o_serial_data_o),
    .o_serial_data_oe_n(o_serial_data_oe_n),
    .i_read_edge_select(i_read_edge_select),
    .i_reg_ready(i_reg_ready),
    .o_reg_valid(o_reg_valid),
    .o_reg_addr(o_reg_addr),
    .o_reg_data(o_reg_data),
    .o_busy(o_busy)
  );
  spi3_master_model mst(.i_ref_clk(i_ref_clk), .i_line(i_serial_data_i),
    .o_sclk(i_serial_clk), .o_cs_n(i_select_low_n), .o_sdi(sdi_m));
  // log committed writes for the scenarios to drain
  always @(posedge i_ref_clk) begin
    if (o_reg_valid === 1'b1) got.push_back({o_reg_addr, o_reg_data});
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // empty queue gives unknowns, so a lost write never matches
  function automatic logic [15:0] next_word();
    return got.size() ? {1'b0, got.pop_front()} : {16{1'bx}};
  endfunction
  // one frame: command byte, then two bytes out or in
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] d,
      output logic [15:0] r);
    mst.frame_on();
    mst.byte_io(cmd, 1'b1, r[7:0]);
    mst.byte_io(d[7:0], !cmd[0], r[7:0]);
    mst.byte_io(d[15:8], !cmd[0], r[15:8]);
    mst.frame_off();
  endtask
  // clocking a write with select high must change nothing
  task automatic idle_ignored();
    logic [15:0] r;
    mst.byte_io({7'h05, 1'b0}, 1'b1, r[7:0]);
    mst.byte_io(8'hEE, 1'b1, r[15:8]);
    mst.frame_off();
    check({14'h0000, o_serial_data_oe_n, o_busy}, 16'h0002);
    check(16'(got.size()), 16'h0000);
  endtask
  task automatic write_burst();
    logic [15:0] r;
    xfer({7'h05, 1'b0}, 16'h3CA5, r);
    check(next_word(), {8'h05, 8'hA5});
    check(next_word(), {8'h06, 8'h3C});
  endtask
  // receiver stalls; both bytes wait in the buffer, for addresses 0x76 and 0x77
  task automatic stall_top();
    logic [15:0] r;
    i_reg_ready <= 1'b0;
    xfer({7'h76, 1'b0}, 16'h2211, r);
    check(16'(got.size()), 16'h0000);
    i_reg_ready <= 1'b1;
    for (int i = 0; i < 40 && got.size() < 2; i++) @(posedge i_ref_clk);
    check(next_word(), {8'h76, 8'h11});
    check(next_word(), {8'h77, 8'h22});
  endtask
  task automatic read_edges();
    logic [15:0] r;
    i_read_edge_select <= 1'b0;
    xfer({7'h05, 1'b1}, 16'h0000, r);
    check(r, 16'h3CA5);
    i_read_edge_select <= 1'b1;
    xfer({7'h76, 1'b1}, 16'h0000, r);
    check(r, 16'h2211);
  endtask
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    idle_ignored();
    write_burst();
    stall_top();
    read_edges();
    end_sim();
  end
  // the scenarios need about 1950 cycles
  initial begin
    repeat (10000) @(posedge i_ref_clk);
    fail_count++;
    end_sim();
  end
  task automatic end_sim();
    if (fail_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
endmodule
